// ===== verif/sff_fifo_assertions.sv
`timescale 1ns/1ns
`default_nettype none
module sff_fifo_chk
  import sff_pkg::*;
#(
  parameter int WIDTH = SFF_WIDTH,
  parameter int DEPTH = SFF_DEPTH
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic fifo_reset_n,
  input wire logic out_enable_n,
  input wire logic offset_load_n,
  input wire logic flag_sync_select,
  input wire logic cascade_mode,
  input wire logic [WIDTH-1:0] rd_data_o,
  input wire logic rd_data_oe,
  input wire logic wr_chain_out,
  input wire logic empty_n,
  input wire logic full_n,
  input wire logic almost_empty_n,
  input wire logic almost_full_n
);
  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence fres_held;
    !fifo_reset_n [*2];
  endsequence
  reset_empty_a: assert property (fres_held |=> !empty_n && full_n)
    else $error("reset cycle left fifo not empty");
  reset_data_a: assert property ($fell(fifo_reset_n) && !out_enable_n |=> rd_data_o == '0)
    else $error("data not cleared by reset");
  oe_off_a: assert property (out_enable_n |-> !rd_data_oe)
    else $error("bus driven with enable high");
  oe_on_a: assert property (!out_enable_n && !cascade_mode |-> rd_data_oe)
    else $error("bus released with enable low");
  offset_hold_a: assert property ((!offset_load_n && fifo_reset_n) [*3] |-> $stable(empty_n))
    else $error("offset access moved the queue");
  aempty_async_a: assert property (flag_sync_select && !empty_n |-> !almost_empty_n)
    else $error("almost empty high while empty");
  afull_full_a: assert property (!full_n |-> !almost_full_n)
    else $error("almost full high while full");
  half_level_a: assert property (!cascade_mode && !empty_n |-> wr_chain_out)
    else $error("half level low while empty");
endmodule
bind sff_fifo sff_fifo_chk #(.WIDTH(WIDTH), .DEPTH(DEPTH)) u_chk (.clk, .rst_n, .fifo_reset_n,
  .out_enable_n, .offset_load_n, .flag_sync_select, .cascade_mode, .rd_data_o, .rd_data_oe,
  .wr_chain_out, .empty_n, .full_n, .almost_empty_n, .almost_full_n);
`default_nettype wire

// ===== verif/sff_peer.sv
`timescale 1ns/1ns
`default_nettype none
module sff_peer (
  input wire logic clk,
  output logic wr_en_n,
  output logic rd_en_n,
  output logic [17:0] wr_data,
  output logic wr_chain_in,
  output logic rd_chain_in
);
  // ------------------------------------------------------------
  // Writer and reader
  // ------------------------------------------------------------
  // A lone device has both chain inputs tied low.
  assign wr_chain_in = 1'b0;
  assign rd_chain_in = 1'b0;
  initial begin
    wr_en_n = 1'b1;
    rd_en_n = 1'b1;
    wr_data = 18'h00000;
  end
  // Released data is inverted so a late sample never matches by luck.
  task automatic op(input logic w, input logic r, input logic [17:0] d);
    @(negedge clk);
    wr_en_n = !w;
    rd_en_n = !r;
    wr_data = d;
    @(negedge clk);
    wr_en_n = 1'b1;
    rd_en_n = 1'b1;
    wr_data = ~d;
    repeat (2) @(negedge clk);
  endtask
endmodule
`default_nettype wire

// ===== verif/test_sync_fifo_flags_cascade_reset.sv
`timescale 1ns/1ns
`default_nettype none
module test_sync_fifo_flags_cascade_reset;
  import sff_pkg::*;
  localparam int DP = 64;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic fifo_reset_n = 1'b1;
  logic out_enable_n = 1'b0;
  logic offset_load_n = 1'b1;
  logic flag_sync_select = 1'b0;
  logic first_in_chain_n = 1'b0;
  logic cascade_mode = 1'b0;
  logic wr_en_n, rd_en_n, wr_chain_in, rd_chain_in, rd_data_oe, wr_chain_out, rd_chain_out;
  logic empty_n, full_n, almost_empty_n, almost_full_n;
  logic [17:0] wr_data, rd_data_o;
  int n_mismatch = 0;
  int cmp_count = 0;
  int q[$];
  int hist[$];
  logic [17:0] last_q = 18'h00000;
  int n_wxo = 0;
  int n_rxo = 0;
  always #10 clk = ~clk;
  // Chain pulses last one cycle, so they are counted away from the launching edge.
  always @(negedge clk) begin
    if (cascade_mode && wr_chain_out) n_wxo++;
    if (cascade_mode && rd_chain_out) n_rxo++;
  end
  sff_peer u_peer (.clk, .wr_en_n, .rd_en_n, .wr_data, .wr_chain_in, .rd_chain_in);
  sff_fifo #(.DEPTH(DP)) u_dut (.clk, .rst_n, .fifo_reset_n, .wr_en_n, .rd_en_n, .wr_data,
    .rd_data_o, .rd_data_oe, .out_enable_n, .offset_load_n, .flag_sync_select,
    .cascade_mode, .first_in_chain_n, .wr_chain_in, .rd_chain_in, .wr_chain_out,
    .rd_chain_out, .empty_n, .full_n, .almost_empty_n, .almost_full_n);
  // ------------------------------------------------------------
  // Compare and transfer tasks
  // ------------------------------------------------------------
  task automatic chk_bit(input string nm, input logic exp, input logic got);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %b seen %b", nm, exp, got);
    end
  endtask
  task automatic chk_word(input string nm, input logic [17:0] exp, input logic [17:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // Offsets are 2 (empty side) and 3 (full side) after every reset.
  task automatic flags();
    chk_bit("empty_n", q.size() != 0, empty_n);
    chk_bit("full_n", q.size() != DP, full_n);
    chk_bit("almost_empty_n", q.size() > 2, almost_empty_n);
    chk_bit("almost_full_n", q.size() < DP - 3, almost_full_n);
    chk_bit("wr_chain_out", !cascade_mode && q.size() <= DP / 2, wr_chain_out);
    chk_bit("rd_chain_out", 1'b0, rd_chain_out);
  endtask
  task automatic wr(input logic [17:0] d);
    u_peer.op(1'b1, 1'b0, d);
    if (q.size() < DP) begin
      q.push_back(d);
      hist.push_back(d);
    end
    flags();
  endtask
  task automatic rd();
    int e;
    e = (q.size() != 0) ? q.pop_front() : -1;
    if (e >= 0) last_q = 18'(e);
    u_peer.op(1'b0, 1'b1, 18'h00000);
    chk_word("rd_data_o", last_q, rd_data_o);
    flags();
  endtask
  // Traffic stays idle while the reset input is low.
  // With the output enable high across the falling edge the last data must stay.
  task automatic fres(input logic oe_n);
    @(negedge clk) fifo_reset_n = 1'b0;
    out_enable_n = oe_n;
    repeat (2) @(negedge clk);
    fifo_reset_n = 1'b1;
    out_enable_n = 1'b0;
    q.delete();
    hist.delete();
    chk_word("rd_data_o", oe_n ? last_q : 18'h00000, rd_data_o);
    offset_load_n = 1'b0;
    u_peer.op(1'b1, 1'b0, 18'h3f002);
    u_peer.op(1'b1, 1'b0, 18'h3f003);
    u_peer.op(1'b0, 1'b1, 18'h00000);
    chk_word("empty_ofs", 18'h002, {6'h00, rd_data_o[11:0]});
    u_peer.op(1'b0, 1'b1, 18'h00000);
    chk_word("full_ofs", 18'h003, {6'h00, rd_data_o[11:0]});
    chk_bit("empty_n", 1'b0, empty_n);
    offset_load_n = 1'b1;
    last_q = 18'h00003;
  endtask
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    #200000;
    n_mismatch++;
    test_done();
  end
  // ------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------
  initial begin
    void'($urandom(51532));
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    fres(1'b0);
    for (int i = 0; i <= DP; i++) wr(18'($urandom));
    @(negedge clk) out_enable_n = 1'b1;
    #1 chk_bit("rd_data_oe", 1'b0, rd_data_oe);
    @(negedge clk) out_enable_n = 1'b0;
    #1 chk_bit("rd_data_oe", 1'b1, rd_data_oe);
    for (int i = 0; i <= DP; i++) rd();
    $display("test fill and drain done");
    flag_sync_select = 1'b1;
    fres(1'b0);
    for (int i = 0; i < 5; i++) wr(18'($urandom));
    for (int i = 0; i < 5; i++) rd();
    @(negedge clk) first_in_chain_n = 1'b1;
    @(negedge clk) first_in_chain_n = 1'b0;
    repeat (2) @(negedge clk);
    q = hist;
    flags();
    for (int i = 0; i < 5; i++) rd();
    $display("test replay done");
    cascade_mode = 1'b1;
    flag_sync_select = 1'b0;
    fres(1'b1);
    for (int i = 0; i <= DP; i++) wr(18'($urandom));
    chk_word("wr_chain pulses", 18'h00001, 18'(n_wxo));
    for (int i = 0; i <= DP; i++) rd();
    chk_word("rd_chain pulses", 18'h00001, 18'(n_rxo));
    chk_bit("rd_data_oe", 1'b0, rd_data_oe);
    $display("test cascade done");
    test_done();
  end
endmodule
`default_nettype wire

// ===== verilog/sff_fifo.sv
`timescale 1ns/1ns
`default_nettype none
// Notes on behaviour
// - Almost-full low at programmed full offset.
// - Mode high gives asynchronous almost flags.
// - Synchronous mode updates flags on clock edges.
// - Offset load routes writes and reads to offsets.
// - Standalone pin strobe performs a retransmit.
// - Read chain output passes read token onward.
// - Reset returns to empty; reset before use.
// - Outputs driven only while enable is low.
// - Array of eighteen-bit words, independent pointers.
// - Outputs go low after reset if enabled.
// - Reset needs falling edge; no traffic meanwhile.
// - Reset leaves empty indicator low.
// - Almost-empty low at or below empty offset.
// - Offset writes alternate empty then full.
module sff_fifo
  import sff_pkg::*;
#(
  parameter int WIDTH = SFF_WIDTH,
  parameter int DEPTH = SFF_DEPTH
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic fifo_reset_n,
  input wire logic wr_en_n,
  input wire logic rd_en_n,
  input wire logic [WIDTH-1:0] wr_data,
  output logic [WIDTH-1:0] rd_data_o,
  output logic rd_data_oe,
  input wire logic out_enable_n,
  input wire logic offset_load_n,
  input wire logic flag_sync_select,
  input wire logic cascade_mode,
  input wire logic first_in_chain_n,
  input wire logic wr_chain_in,
  input wire logic rd_chain_in,
  output logic wr_chain_out,
  output logic rd_chain_out,
  output logic empty_n,
  output logic full_n,
  output logic almost_empty_n,
  output logic almost_full_n
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = AW + 1;
  // Flag compares need room for the count plus a full offset, or a large offset wraps.
  localparam int FW = ((CW > SFF_OFS_WIDTH) ? CW : SFF_OFS_WIDTH) + 1;

  if (DEPTH < SFF_DEPTH_MIN || DEPTH > SFF_DEPTH_MAX || (1 << AW) != DEPTH
      || WIDTH < SFF_OFS_WIDTH) begin : g_bad_geometry
    $error("Unsupported FIFO geometry.");
  end

  // ----------------------------------------
  // Pointer, count and offset state.
  // ----------------------------------------
  logic [AW-1:0] wptr_reg, wptr_next, rptr_reg, rptr_next;
  logic [CW-1:0] count_reg, count_next;
  logic [SFF_OFS_WIDTH-1:0] eofs_reg, eofs_next, fofs_reg, fofs_next;
  logic wsel_reg, wsel_next, rsel_reg, rsel_next;
  logic [WIDTH-1:0] q_reg, q_next;
  logic fres_d_reg, fres_d_next, rt_d_reg, rt_d_next;
  logic empty_reg, empty_next, full_reg, full_next;
  logic ae_reg, ae_next, af_reg, af_next;
  logic wtok_reg, wtok_next, rtok_reg, rtok_next;
  logic rchain_reg, rchain_next, wchain_reg, wchain_next;
  logic [WIDTH-1:0] ram_q;
  logic do_wr, do_rd, in_reset, standalone, replay_strobe, rt_rise, ae_now, af_now;
  logic [CW-1:0] full_lim;
  logic ae_live, af_live;

  // The shared first-load pin acts as replay strobe outside a cascade.
  assign standalone = ~cascade_mode;
  assign replay_strobe = standalone & first_in_chain_n;
  assign rt_rise = replay_strobe & ~rt_d_reg;
  assign in_reset = ~fifo_reset_n;
  assign full_lim = CW'(DEPTH);
  // Offset accesses never touch the queue pointers.
  assign do_wr = ~in_reset & offset_load_n & ~wr_en_n & ~full_reg & wtok_reg;
  assign do_rd = ~in_reset & offset_load_n & ~rd_en_n & ~empty_reg & rtok_reg;
  assign ae_now = FW'(count_next) <= FW'(eofs_next);
  assign af_now = FW'(count_next) + FW'(fofs_next) >= FW'(DEPTH);
  assign ae_live = FW'(count_reg) <= FW'(eofs_reg);
  assign af_live = FW'(count_reg) + FW'(fofs_reg) >= FW'(DEPTH);

  sff_ram #(.WIDTH(WIDTH), .DEPTH(DEPTH), .AW(AW)) u_ram (
    .clk(clk),
    .wr_en(do_wr),
    .wr_addr(wptr_reg),
    .wr_data(wr_data),
    .rd_addr(rptr_reg),
    .rd_data(ram_q)
  );

  // ----------------------------------------
  // Next-state logic.
  // ----------------------------------------
  always_comb begin
    wptr_next = wptr_reg;
    rptr_next = rptr_reg;
    count_next = count_reg;
    eofs_next = eofs_reg;
    fofs_next = fofs_reg;
    wsel_next = wsel_reg;
    rsel_next = rsel_reg;
    q_next = q_reg;
    wtok_next = wtok_reg;
    rtok_next = rtok_reg;
    rchain_next = 1'b0;
    wchain_next = 1'b0;
    fres_d_next = fifo_reset_n;
    rt_d_next = replay_strobe;
    if (in_reset) begin
      // A held-low reset restarts everything; a falling edge with the output enable low clears data too.
      wptr_next = '0;
      rptr_next = '0;
      count_next = '0;
      wsel_next = SFF_SEL_EMPTY;
      rsel_next = SFF_SEL_EMPTY;
      eofs_next = SFF_EMPTY_OFS_RST;
      fofs_next = SFF_FULL_OFS_RST;
      wtok_next = ~(cascade_mode & first_in_chain_n);
      rtok_next = ~(cascade_mode & first_in_chain_n);
      if (fres_d_reg && !out_enable_n) begin
        q_next = '0;
      end
    end else if (!offset_load_n) begin
      if (!wr_en_n) begin
        if (wsel_reg == SFF_SEL_EMPTY) begin
          eofs_next = wr_data[SFF_OFS_WIDTH-1:0];
        end else begin
          fofs_next = wr_data[SFF_OFS_WIDTH-1:0];
        end
        wsel_next = ~wsel_reg;
      end
      if (!rd_en_n) begin
        q_next = '0;
        q_next[SFF_OFS_WIDTH-1:0] = (rsel_reg == SFF_SEL_EMPTY) ? eofs_reg : fofs_reg;
        rsel_next = ~rsel_reg;
      end
    end else if (rt_rise) begin
      rptr_next = '0;
      count_next = CW'(wptr_reg);
    end else begin
      if (do_wr) begin
        wptr_next = AW'(wptr_reg + 1'b1);
      end
      if (do_rd) begin
        q_next = ram_q;
        rptr_next = AW'(rptr_reg + 1'b1);
      end
      count_next = CW'(count_reg + CW'(do_wr) - CW'(do_rd));
      if (cascade_mode) begin
        // Hand the token on when the last location is used.
        if (do_wr && wptr_reg == AW'(DEPTH - 1)) begin
          wtok_next = 1'b0;
          wchain_next = 1'b1;
        end else if (wr_chain_in) begin
          wtok_next = 1'b1;
        end
        if (do_rd && rptr_reg == AW'(DEPTH - 1)) begin
          rtok_next = 1'b0;
          rchain_next = 1'b1;
        end else if (rd_chain_in) begin
          rtok_next = 1'b1;
        end
      end
    end
    empty_next = count_next == '0;
    full_next = count_next == full_lim;
    ae_next = ae_now;
    af_next = af_now;
  end

  // ----------------------------------------
  // Registers.
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wptr_reg <= '0;
      rptr_reg <= '0;
      count_reg <= '0;
      eofs_reg <= SFF_EMPTY_OFS_RST;
      fofs_reg <= SFF_FULL_OFS_RST;
      wsel_reg <= SFF_SEL_EMPTY;
      rsel_reg <= SFF_SEL_EMPTY;
      q_reg <= '0;
      wtok_reg <= 1'b1;
      rtok_reg <= 1'b1;
      rchain_reg <= 1'b0;
      wchain_reg <= 1'b0;
      fres_d_reg <= 1'b1;
      rt_d_reg <= 1'b0;
      empty_reg <= 1'b1;
      full_reg <= 1'b0;
      ae_reg <= 1'b1;
      af_reg <= 1'b0;
    end else begin
      wptr_reg <= wptr_next;
      rptr_reg <= rptr_next;
      count_reg <= count_next;
      eofs_reg <= eofs_next;
      fofs_reg <= fofs_next;
      wsel_reg <= wsel_next;
      rsel_reg <= rsel_next;
      q_reg <= q_next;
      wtok_reg <= wtok_next;
      rtok_reg <= rtok_next;
      rchain_reg <= rchain_next;
      wchain_reg <= wchain_next;
      fres_d_reg <= fres_d_next;
      rt_d_reg <= rt_d_next;
      empty_reg <= empty_next;
      full_reg <= full_next;
      ae_reg <= ae_next;
      af_reg <= af_next;
    end
  end

  // ----------------------------------------
  // Outputs.
  // ----------------------------------------
  // Both ports share one clock here, so the asynchronous mode is
  // modelled as flags that follow the count without a register stage.
  assign almost_empty_n = flag_sync_select ? ~ae_live : ~ae_reg;
  assign almost_full_n = flag_sync_select ? ~af_live : ~af_reg;
  assign empty_n = ~empty_reg;
  assign full_n = ~full_reg;
  assign rd_data_o = q_reg;
  assign rd_data_oe = ~out_enable_n & (~cascade_mode | rtok_reg);
  assign rd_chain_out = rchain_reg;
  // Outside a cascade this pin reports the half level, active low.
  assign wr_chain_out = cascade_mode ? wchain_reg : ~(count_reg > CW'(DEPTH / 2));
endmodule
`default_nettype wire

// ===== verilog/sff_pkg.sv
package sff_pkg;
  localparam int SFF_WIDTH = 18;
  localparam int SFF_DEPTH = 1024;
  localparam int SFF_DEPTH_MIN = 64;
  localparam int SFF_DEPTH_MAX = 4096;
  localparam int SFF_OFS_WIDTH = 12;
  localparam logic [11:0] SFF_EMPTY_OFS_RST = 12'h07f;
  localparam logic [11:0] SFF_FULL_OFS_RST = 12'h07f;
  localparam logic SFF_SEL_EMPTY = 1'b0;
  localparam logic SFF_SEL_FULL = 1'b1;
  typedef enum logic [1:0] {SFF_ST_RESET, SFF_ST_RUN, SFF_ST_OFFSET} sff_state_t;
endpackage

// ===== verilog/sff_ram.sv
`timescale 1ns/1ns
`default_nettype none
module sff_ram #(
  parameter int WIDTH = 18,
  parameter int DEPTH = 1024,
  parameter int AW = 10
) (
  input wire logic clk,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data,
  input wire logic [AW-1:0] rd_addr,
  output logic [WIDTH-1:0] rd_data
);
  // ----------------------------------------
  // Storage with independent read and write ports.
  // ----------------------------------------
  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  assign rd_data = mem[rd_addr];
endmodule
`default_nettype wire
